//--- core_model.sv
// Purpose: processor core stand-in that accepts and ends handlers
// Assumes: bench commands change just after a rising edge
// Notes: one accept pulse per command, only while a request shows
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_req,
  input wire logic [4:0] irq_num,
  input wire logic auto_ack,
  input wire logic ret_cmd,
  output logic irq_ack,
  output logic irq_return,
  output logic [4:0] acc_num
);
  // accept pulse, return pulse, accepted number
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack <= 1'h0;
      irq_return <= 1'h0;
      acc_num <= 5'h00;
    end else begin
      irq_ack <= irq_req && auto_ack && !irq_ack;
      irq_return <= ret_cmd;
      if (irq_ack && irq_req) begin
        acc_num <= irq_num;
      end
    end
  end
endmodule
`default_nettype wire

//--- irq_ctrl_pkg.sv
// Purpose: shared constants for the nested priority interrupt controller
// Assumes: APB slave at 32-bit data, one word per register
// Notes: priority words sit one per source from PRIO_BASE upward
// How it works
// - thirty-two source inputs resolved into eight hardware priority levels
// - each source has its own enable; disabled sources never request
// - global mask gates the one request line, enables stay untouched
// - while globally masked only the non-maskable input still reaches the core
// - global mask state is readable before software changes it
// - controller enables never touch enables inside the peripherals
// - winning source's handler address is handed straight to the core
// - pending interrupt with a more urgent preemption field preempts a running handler with a less urgent one
// - 8-bit priority stored per source, only upper 3 bits arbitrate
// - smaller priority value is more urgent, zero most urgent
// - grouping splits compared bits; only preemption bits decide preemption
// - equal preemption, different subpriority: no preemption, request waits until the running handler returns
// - full tie goes to the lower interrupt number
// - nesting depth tracked; thread return when the last nested handler ends, even with a request pending
// - handler table base is 1 kB aligned; software must place it so
// - stored priority value reads back through the same registers
// - grouping values three through seven behave identically
package irq_ctrl_pkg;

  // sizes
  localparam int NUM_SRC = 32;
  localparam int SRC_W = 5;
  localparam int PRIO_W = 8;
  localparam int CMP_W = 3;
  localparam int STACK_DEPTH = 8;
  localparam int DEPTH_W = 4;
  localparam int GROUP_W = 3;
  localparam int ADDR_W = 12;
  localparam int VTBASE_W = 22;
  localparam int VTBASE_LSB = 10;

  // register byte offsets
  localparam logic [11:0] ENABLE_OFS = 12'h000;
  localparam logic [11:0] ENABLE_SET_OFS = 12'h004;
  localparam logic [11:0] ENABLE_CLR_OFS = 12'h008;
  localparam logic [11:0] GLOBAL_OFS = 12'h00C;
  localparam logic [11:0] GROUP_OFS = 12'h010;
  localparam logic [11:0] VTBASE_OFS = 12'h014;
  localparam logic [11:0] STATUS_OFS = 12'h018;
  localparam logic [11:0] PENDING_OFS = 12'h01C;
  localparam logic [11:0] PRIO_BASE = 12'h100;
  localparam logic [4:0] PRIO_PAGE = 5'h02;

  // field positions
  localparam int MASK_BIT = 0;
  localparam int STAT_NUM_LSB = 0;
  localparam int STAT_DEPTH_LSB = 8;
  localparam int STAT_REQ_BIT = 16;
  localparam int STAT_NMI_BIT = 17;

  // reset values
  localparam logic MASK_RST = 1'b0;
  localparam logic [GROUP_W-1:0] GROUP_RST = 3'h7;
  localparam logic [VTBASE_W-1:0] VTBASE_RST = 22'h000000;

  // first table slot used by source 0
  localparam logic [6:0] VEC_OFFSET = 7'h10;

endpackage

//--- nested_priority_interrupt_ctrl.sv
// Purpose: nested, vectored, prioritised interrupt controller with APB registers
// Assumes: sources are level signals on pclk; nmi_in arrives asynchronously
// Notes: core accepts with irq_ack and ends a handler with irq_return
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module nested_priority_interrupt_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [irq_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral sources and non-maskable pin
  input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] src_irq,
  input wire logic nmi_in,
  // core side
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic irq_req,
  output logic [31:0] irq_vector,
  output logic [irq_ctrl_pkg::SRC_W-1:0] irq_num,
  output logic nmi_req,
  output logic handler_active
);

  typedef struct packed {
    logic [irq_ctrl_pkg::NUM_SRC-1:0] enable;
    logic [irq_ctrl_pkg::NUM_SRC-1:0] pending;
    logic [irq_ctrl_pkg::NUM_SRC-1:0][irq_ctrl_pkg::PRIO_W-1:0] prio;
    logic glob_mask;
    logic [irq_ctrl_pkg::GROUP_W-1:0] group;
    logic [irq_ctrl_pkg::VTBASE_W-1:0] vtbase;
    logic [irq_ctrl_pkg::DEPTH_W-1:0] depth;
    logic [irq_ctrl_pkg::STACK_DEPTH-1:0][irq_ctrl_pkg::CMP_W-1:0] stk_prio;
    logic [irq_ctrl_pkg::STACK_DEPTH-1:0][irq_ctrl_pkg::SRC_W-1:0] stk_num;
    logic req;
    logic [31:0] vector;
    logic [irq_ctrl_pkg::SRC_W-1:0] num;
    logic [31:0] prdata;
    logic [1:0] nmi_sync;
  } ctrl_state_type;

  ctrl_state_type state_ff;
  ctrl_state_type nxt_state;

  // arbiter wiring
  logic [irq_ctrl_pkg::NUM_SRC-1:0] cand;
  logic [irq_ctrl_pkg::NUM_SRC-1:0][irq_ctrl_pkg::CMP_W-1:0] prio_top;
  logic win_valid;
  logic [irq_ctrl_pkg::SRC_W-1:0] win_num;
  logic [irq_ctrl_pkg::CMP_W-1:0] win_prio;

  // decode and control terms
  logic acc_phase;
  logic setup_phase;
  logic wr_en;
  logic addr_hit;
  logic prio_hit;
  logic [irq_ctrl_pkg::SRC_W-1:0] prio_idx;
  logic [31:0] rd_data;
  logic [irq_ctrl_pkg::CMP_W-1:0] pre_mask;
  logic [irq_ctrl_pkg::CMP_W-1:0] run_prio;
  logic can_preempt;
  logic ack_take;
  logic ret_take;
  logic [irq_ctrl_pkg::DEPTH_W-1:0] top_idx;
  logic [irq_ctrl_pkg::DEPTH_W-1:0] push_idx;
  logic [9:0] vec_low;
  logic [6:0] vec_slot;

  // only the upper compared bits of each priority reach the arbiter
  genvar i;
  generate
    for (i = 0; i < irq_ctrl_pkg::NUM_SRC; i++) begin : g_top
      assign prio_top[i] = state_ff.prio[i][irq_ctrl_pkg::PRIO_W-1 -: irq_ctrl_pkg::CMP_W];
    end
  endgenerate

  // a source competes only while pending and enabled here
  assign cand = state_ff.pending & state_ff.enable;

  prio_arbiter u_arb (
    .cand(cand),
    .prio_top(prio_top),
    .win_valid(win_valid),
    .win_num(win_num),
    .win_prio(win_prio)
  );

  // apb phases
  assign setup_phase = psel & ~penable;
  assign acc_phase = psel & penable;
  assign prio_hit = (paddr[11:7] == irq_ctrl_pkg::PRIO_PAGE) && (paddr[1:0] == 2'h0);
  assign prio_idx = paddr[6:2];

  // address decode and read mux
  always_comb begin
    addr_hit = 1'b1;
    rd_data = 32'h0000_0000;
    if (prio_hit) begin
      rd_data[irq_ctrl_pkg::PRIO_W-1:0] = state_ff.prio[prio_idx];
    end else begin
      case (paddr)
        irq_ctrl_pkg::ENABLE_OFS,
        irq_ctrl_pkg::ENABLE_SET_OFS,
        irq_ctrl_pkg::ENABLE_CLR_OFS: begin
          rd_data = state_ff.enable;
        end
        irq_ctrl_pkg::GLOBAL_OFS: begin
          rd_data[irq_ctrl_pkg::MASK_BIT] = state_ff.glob_mask;
        end
        irq_ctrl_pkg::GROUP_OFS: begin
          rd_data[irq_ctrl_pkg::GROUP_W-1:0] = state_ff.group;
        end
        irq_ctrl_pkg::VTBASE_OFS: begin
          rd_data[31:irq_ctrl_pkg::VTBASE_LSB] = state_ff.vtbase;
        end
        irq_ctrl_pkg::STATUS_OFS: begin
          rd_data[irq_ctrl_pkg::STAT_NUM_LSB +: irq_ctrl_pkg::SRC_W] =
            state_ff.stk_num[3'(top_idx)];
          rd_data[irq_ctrl_pkg::STAT_DEPTH_LSB +: irq_ctrl_pkg::DEPTH_W] = state_ff.depth;
          rd_data[irq_ctrl_pkg::STAT_REQ_BIT] = state_ff.req;
          rd_data[irq_ctrl_pkg::STAT_NMI_BIT] = state_ff.nmi_sync[1];
        end
        irq_ctrl_pkg::PENDING_OFS: begin
          rd_data = state_ff.pending;
        end
        default: begin
          addr_hit = 1'b0;
        end
      endcase
    end
  end

  // write strobe valid only in the completing access cycle
  assign wr_en = acc_phase & pwrite & addr_hit & clk_en;

  // preemption field mask from grouping; 3..7 all give full preemption
  always_comb begin
    if (state_ff.group >= 3'h3) begin
      pre_mask = 3'h7;
    end else begin
      pre_mask = ~(3'h7 >> state_ff.group);
    end
  end

  // running handler priority is the top of the nesting stack
  assign top_idx = (state_ff.depth == 4'h0) ? 4'h0 : state_ff.depth - 4'h1;
  assign run_prio = state_ff.stk_prio[3'(top_idx)];

  // strictly more urgent preemption field is needed to nest
  assign can_preempt = (state_ff.depth == 4'h0) ||
                       ((win_prio & pre_mask) < (run_prio & pre_mask));

  // core handshakes
  assign ack_take = state_ff.req & irq_ack;
  assign ret_take = irq_return & (state_ff.depth != 4'h0);
  // a return with an accept in the same cycle replaces the top entry
  assign push_idx = ret_take ? top_idx : state_ff.depth;

  // handler address: 1 kB aligned base plus word slot of the winner
  assign vec_slot = irq_ctrl_pkg::VEC_OFFSET + {2'h0, win_num};
  assign vec_low = {1'b0, vec_slot, 2'h0};

  // next state
  always_comb begin
    nxt_state = state_ff;

    // two-stage synchroniser for the asynchronous non-maskable pin
    nxt_state.nmi_sync = {state_ff.nmi_sync[0], nmi_in};

    // read data captured in the setup cycle
    if (setup_phase) begin
      nxt_state.prdata = rd_data;
    end

    // register writes
    if (wr_en) begin
      if (prio_hit) begin
        nxt_state.prio[prio_idx] = pwdata[irq_ctrl_pkg::PRIO_W-1:0];
      end else begin
        case (paddr)
          irq_ctrl_pkg::ENABLE_OFS: begin
            nxt_state.enable = pwdata;
          end
          irq_ctrl_pkg::ENABLE_SET_OFS: begin
            // source_enable_call; local enable only, no peripheral side effect
            nxt_state.enable = state_ff.enable | pwdata;
          end
          irq_ctrl_pkg::ENABLE_CLR_OFS: begin
            // source_disable_call
            nxt_state.enable = state_ff.enable & ~pwdata;
          end
          irq_ctrl_pkg::GLOBAL_OFS: begin
            // global_mask_call and global_unmask_call touch only this bit
            nxt_state.glob_mask = pwdata[irq_ctrl_pkg::MASK_BIT];
          end
          irq_ctrl_pkg::GROUP_OFS: begin
            nxt_state.group = pwdata[irq_ctrl_pkg::GROUP_W-1:0];
          end
          irq_ctrl_pkg::VTBASE_OFS: begin
            // low ten bits are not stored, table sits on a 1 kB boundary
            nxt_state.vtbase = pwdata[31:irq_ctrl_pkg::VTBASE_LSB];
          end
          default: begin
            nxt_state.glob_mask = state_ff.glob_mask;
          end
        endcase
      end
    end

    // pending: accepted source clears, but a live enabled source sets again
    nxt_state.pending = state_ff.pending;
    if (ack_take) begin
      nxt_state.pending[state_ff.num] = 1'b0;
    end
    nxt_state.pending = nxt_state.pending | (src_irq & state_ff.enable);

    // nesting stack
    if (ack_take && (push_idx < 4'(irq_ctrl_pkg::STACK_DEPTH))) begin
      nxt_state.stk_prio[3'(push_idx)] = state_ff.prio[state_ff.num]
        [irq_ctrl_pkg::PRIO_W-1 -: irq_ctrl_pkg::CMP_W];
      nxt_state.stk_num[3'(push_idx)] = state_ff.num;
      nxt_state.depth = push_idx + 4'h1;
    end else if (ret_take) begin
      nxt_state.depth = state_ff.depth - 4'h1;
    end

    // request: held off for the cycle of an accept or return so it
    // always reflects the updated stack; rearbitrated every cycle
    nxt_state.req = ~state_ff.glob_mask & win_valid & can_preempt &
                    ~ack_take & ~ret_take;
    nxt_state.num = win_num;
    nxt_state.vector = {state_ff.vtbase, vec_low};
  end

  // state register; clock enable freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
      state_ff.glob_mask <= irq_ctrl_pkg::MASK_RST;
      state_ff.group <= irq_ctrl_pkg::GROUP_RST;
      state_ff.vtbase <= irq_ctrl_pkg::VTBASE_RST;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // apb answers: one access cycle, error on unmapped offsets
  assign pready = acc_phase & clk_en;
  assign pslverr = acc_phase & clk_en & ~addr_hit;
  assign prdata = state_ff.prdata;

  // core outputs
  assign irq_req = state_ff.req;
  assign irq_vector = state_ff.vector;
  assign irq_num = state_ff.num;
  assign nmi_req = state_ff.nmi_sync[1];
  assign handler_active = (state_ff.depth != 4'h0);

endmodule
`default_nettype wire

//--- nested_priority_interrupt_ctrl_asserts.sv
// Purpose: port assertions for the interrupt controller
// Assumes: one pclk domain, presetn active low
// Notes: attached to every controller instance by bind
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic irq_ack,
  input wire logic irq_return,
  input wire logic irq_req,
  input wire logic [31:0] irq_vector,
  input wire logic [irq_ctrl_pkg::SRC_W-1:0] irq_num,
  input wire logic nmi_in,
  input wire logic nmi_req,
  input wire logic handler_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // accept drops the request and opens a handler
  chk_ack_drop: assert property (irq_req && irq_ack && clk_en |=> !irq_req && handler_active)
    else $error("request stayed up after accept");
  chk_active_cause: assert property ($rose(handler_active) |-> $past(irq_req && irq_ack && clk_en))
    else $error("handler opened without accept");
  chk_ret_drop: assert property (irq_return && handler_active && clk_en |=> !irq_req)
    else $error("request stayed up after return");
  // a shown request holds until an accept, a return or an apb write
  chk_pend_hold: assert property (irq_req && !irq_ack && !irq_return && clk_en && !(psel && pwrite)
    && !$past(psel && pwrite) |=> irq_req)
    else $error("request lost before accept");
  // handler slot follows the source number
  chk_vec_slot: assert property (irq_req |-> irq_vector[9:0] == 10'((irq_num + 10'h010) << 2))
    else $error("vector slot wrong");
  // non-maskable path is two stages, mask never gates it
  chk_nmi_path: assert property ($past(clk_en) && $past(clk_en, 2) |-> nmi_req == $past(nmi_in, 2))
    else $error("nmi request not two stages behind pin");
  chk_freeze_hold: assert property (!clk_en |=> $stable(irq_req) && $stable(irq_num))
    else $error("state moved while frozen");
  chk_apb_ready: assert property (pready == (psel && penable && clk_en))
    else $error("ready not zero wait");
endmodule
bind nested_priority_interrupt_ctrl irq_ctrl_asserts u_irq_ctrl_asserts (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .irq_ack(irq_ack), .irq_return(irq_return),
  .irq_req(irq_req), .irq_vector(irq_vector), .irq_num(irq_num), .nmi_in(nmi_in),
  .nmi_req(nmi_req), .handler_active(handler_active));
`default_nettype wire

//--- nested_priority_interrupt_ctrl_tb_top.sv
// Purpose: register and nesting tests of the interrupt controller
// Assumes: zero wait apb, core model on the request side
// Notes: core-side outputs sampled on the falling edge, apb read data on a rising edge
`timescale 1ns/1ns
`default_nettype none
module nested_priority_interrupt_ctrl_tb_top;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, rerr;
  logic irq_ack, irq_return, irq_req, nmi_in, nmi_req, handler_active, auto_ack, ret_cmd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, irq_vector, rdat, src_irq;
  logic [4:0] irq_num, acc_num;
  int n_fail, checks_done;
  nested_priority_interrupt_ctrl u_nested_priority_interrupt_ctrl (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_irq(src_irq), .nmi_in(nmi_in), .irq_ack(irq_ack), .irq_return(irq_return),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_num(irq_num), .nmi_req(nmi_req),
    .handler_active(handler_active));
  core_model u_core_model (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .irq_num(irq_num), .auto_ack(auto_ack), .ret_cmd(ret_cmd), .irq_ack(irq_ack),
    .irq_return(irq_return), .acc_num(acc_num));
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // setup then access, held until ready at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (i == 16) begin
      n_fail++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic wait_req();
    int i;
    for (i = 0; i < 16; i++) begin
      @(negedge pclk);
      if (irq_req === 1'h1) break;
    end
    if (i == 16) begin
      n_fail++;
      finish_test();
    end
  endtask
  // r low: core accepts, r high: core ends handler
  task automatic pulse(input logic r);
    @(posedge pclk);
    if (r) ret_cmd <= 1'h1;
    else auto_ack <= 1'h1;
    @(posedge pclk);
    ret_cmd <= 1'h0;
    auto_ack <= 1'h0;
    repeat (3) @(negedge pclk);
  endtask
  task automatic src(input int n, input logic v);
    @(posedge pclk);
    src_irq[n] <= v;
  endtask
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, nmi_in, auto_ack, ret_cmd} = 7'h00;
    {clk_en, paddr, pwdata, src_irq, n_fail, checks_done} = {1'h1, 140'h0};
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rd(irq_ctrl_pkg::ENABLE_OFS, 32'h0);
    rd(irq_ctrl_pkg::GLOBAL_OFS, 32'h0);
    rd(irq_ctrl_pkg::GROUP_OFS, 32'h7);
    rd(irq_ctrl_pkg::PRIO_BASE + 12'h01C, 32'h0);
    apb(1'h0, 12'h020, 32'h0);
    chk(32'(rerr), 32'h1);
    wr(irq_ctrl_pkg::PRIO_BASE + 12'h014, 32'h000000A7);
    rd(irq_ctrl_pkg::PRIO_BASE + 12'h014, 32'h000000A7);
    wr(irq_ctrl_pkg::VTBASE_OFS, 32'h000007FF);
    rd(irq_ctrl_pkg::VTBASE_OFS, 32'h00000400);
    src(5, 1'h1);
    repeat (4) @(negedge pclk);
    chk(32'(irq_req), 32'h0);
    wr(irq_ctrl_pkg::ENABLE_SET_OFS, 32'h20);
    wait_req();
    chk(32'(irq_num), 32'h5);
    chk(irq_vector, 32'h00000454);
    wr(irq_ctrl_pkg::GLOBAL_OFS, 32'h1);
    nmi_in <= 1'h1;
    repeat (3) @(negedge pclk);
    chk(32'(irq_req), 32'h0);
    chk(32'(nmi_req), 32'h1);
    rd(irq_ctrl_pkg::GLOBAL_OFS, 32'h1);
    rd(irq_ctrl_pkg::ENABLE_OFS, 32'h20);
    nmi_in <= 1'h0;
    wr(irq_ctrl_pkg::GLOBAL_OFS, 32'h0);
    wait_req();
    src(5, 1'h0);
    repeat (3) @(negedge pclk);
    chk(32'(irq_req), 32'h1);
    pulse(1'h0);
    chk(32'(acc_num), 32'h5);
    rd(irq_ctrl_pkg::STATUS_OFS, 32'h00000105);
    wr(irq_ctrl_pkg::GROUP_OFS, 32'h3);
    wr(irq_ctrl_pkg::PRIO_BASE + 12'h01C, 32'h20);
    src(7, 1'h1);
    wr(irq_ctrl_pkg::ENABLE_SET_OFS, 32'h80);
    wait_req();
    chk(32'(irq_num), 32'h7);
    src(7, 1'h0);
    pulse(1'h0);
    rd(irq_ctrl_pkg::STATUS_OFS, 32'h00000207);
    wr(irq_ctrl_pkg::GROUP_OFS, 32'h0);
    src(9, 1'h1);
    src(2, 1'h1);
    wr(irq_ctrl_pkg::ENABLE_SET_OFS, 32'h204);
    repeat (4) @(negedge pclk);
    chk(32'(irq_req), 32'h0);
    pulse(1'h1);
    chk(32'(irq_req), 32'h0);
    pulse(1'h1);
    wait_req();
    chk(32'(irq_num), 32'h2);
    chk(32'(handler_active), 32'h0);
    src(2, 1'h0);
    pulse(1'h0);
    pulse(1'h1);
    wait_req();
    chk(32'(irq_num), 32'h9);
    @(posedge pclk);
    clk_en <= 1'h0;
    repeat (3) @(negedge pclk);
    chk(32'(irq_req), 32'h1);
    @(posedge pclk);
    clk_en <= 1'h1;
    wr(irq_ctrl_pkg::ENABLE_CLR_OFS, 32'h204);
    repeat (3) @(negedge pclk);
    chk(32'(irq_req), 32'h0);
    rd(irq_ctrl_pkg::ENABLE_OFS, 32'hA0);
    wr(irq_ctrl_pkg::ENABLE_OFS, 32'h0);
    rd(irq_ctrl_pkg::ENABLE_SET_OFS, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire

//--- prio_arbiter.sv
// Purpose: picks the most urgent candidate source
// Assumes: candidates already qualified by enable and pending
// Notes: purely combinational, key is {invalid, priority, number}
`timescale 1ns/1ns
`default_nettype none
module prio_arbiter (
  input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] cand,
  input wire logic [irq_ctrl_pkg::NUM_SRC-1:0][irq_ctrl_pkg::CMP_W-1:0] prio_top,
  output logic win_valid,
  output logic [irq_ctrl_pkg::SRC_W-1:0] win_num,
  output logic [irq_ctrl_pkg::CMP_W-1:0] win_prio
);

  localparam int KEY_W = 1 + irq_ctrl_pkg::CMP_W + irq_ctrl_pkg::SRC_W;

  logic [irq_ctrl_pkg::NUM_SRC:0][KEY_W-1:0] best;

  // seed loses to every real candidate
  assign best[0] = {KEY_W{1'b1}};

  // linear min chain; strict less keeps the lower number on ties
  genvar i;
  generate
    for (i = 0; i < irq_ctrl_pkg::NUM_SRC; i++) begin : g_src
      logic [KEY_W-1:0] key;
      assign key = {~cand[i], prio_top[i], irq_ctrl_pkg::SRC_W'(i)};
      assign best[i+1] = (key < best[i]) ? key : best[i];
    end
  endgenerate

  assign win_valid = ~best[irq_ctrl_pkg::NUM_SRC][KEY_W-1];
  assign win_prio = best[irq_ctrl_pkg::NUM_SRC][KEY_W-2 -: irq_ctrl_pkg::CMP_W];
  assign win_num = best[irq_ctrl_pkg::NUM_SRC][irq_ctrl_pkg::SRC_W-1:0];

endmodule
`default_nettype wire
